// ===== fe_pkg.sv
// Shared constants, types and helpers of the front-end control link and its ends
package fe_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_NS = 50;
   localparam int TRANS_US = 20;
   localparam int TRANS_CYC = TRANS_US * 1000 / CLK_NS;
   localparam logic [8:0] TRANS_LOAD = 9'(TRANS_CYC);
   localparam int HALF_NS = 500;
   localparam int HALF_CYC = HALF_NS / CLK_NS;
   localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);

   // ****************************************
   // Framing
   // ****************************************
   localparam logic [3:0] SID_BCAST = 4'h0;
   localparam logic [3:0] SID_UNIQUE = 4'h5;
   localparam logic [3:0] SID_GROUP = 4'h0;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_READ = 3'h3;
   localparam int HDR_BITS = 13;
   localparam int DATA_BITS = 9;
   localparam int FRM_BITS = HDR_BITS + DATA_BITS;
   localparam logic [3:0] HDR_LAST = 4'(HDR_BITS - 1);
   localparam logic [3:0] DATA_LAST = 4'(DATA_BITS - 1);
   localparam logic [4:0] SHORT_LAST = 5'(HDR_BITS - 1);
   localparam logic [4:0] LONG_LAST = 5'(FRM_BITS - 1);
   localparam logic [4:0] RD_LAST = 5'(DATA_BITS - 1);

   // ****************************************
   // Device registers
   // ****************************************
   localparam logic [4:0] ADDR_LEVEL = 5'h00;
   localparam logic [4:0] ADDR_POLICY = 5'h01;
   localparam logic [4:0] ADDR_AUX = 5'h02;
   localparam logic [4:0] ADDR_TRIG = 5'h1c;
   localparam logic [4:0] ADDR_PRODUCT = 5'h1d;
   localparam int FLD_HI = 7;
   localparam int TRIG_HI = 5;
   localparam logic [6:0] LEVEL_RESET = 7'h00;
   localparam logic [6:0] LEVEL_LOW_POWER = 7'h00;
   localparam logic [6:0] LEVEL_STANDBY = 7'h02;
   localparam logic [6:0] LEVEL_MIN = 7'h0b;
   localparam logic [6:0] LEVEL_MAX = 7'h75;
   localparam logic [6:0] LEVEL_PWM_DIG = 7'h29;
   localparam logic [6:0] LEVEL_PWM_LOAD = 7'h39;

   typedef enum logic [1:0] {
      POLICY_PFM = 2'b00, POLICY_LOW_V = 2'b01, POLICY_LOAD = 2'b10, POLICY_PWM = 2'b11
   } policy_t;
   localparam policy_t POLICY_RESET = POLICY_LOW_V;

   typedef enum logic [1:0] {
      PS_NORMAL = 2'b00, PS_DEFAULT = 2'b01, PS_LOW = 2'b10, PS_RSVD = 2'b11
   } pstate_t;

   typedef enum logic [1:0] {
      OP_LOW = 2'b00, OP_STBY = 2'b01, OP_PFM = 2'b10, OP_PWM = 2'b11
   } op_mode_t;

   // ****************************************
   // Master command registers
   // ****************************************
   localparam logic [1:0] HREG_CMD = 2'h0;
   localparam logic [1:0] HREG_STATUS = 2'h1;
   localparam logic [1:0] HREG_SUPPLY = 2'h2;
   localparam int KIND_LO = 0;
   localparam int SID_LO = 4;
   localparam int ADDR_LO = 8;
   localparam int WDAT_LO = 16;
   localparam logic [1:0] KIND_REG0 = 2'h0;
   localparam logic [1:0] KIND_WRITE = 2'h1;
   localparam logic [1:0] KIND_READ = 2'h2;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_PERR = 2;
   localparam int ST_SUPPLY = 3;
   localparam int ST_RDATA_LO = 8;

   // Odd parity bit over up to twelve bits
   function automatic logic odd_par(input logic [11:0] v);
      return ~^v;
   endfunction

endpackage

// ===== fe_link_if.sv
// Two-wire control link with its interface supply pin
interface fe_link_if;
   logic sclk;
   logic io_supply_enable;
   logic sdata_m_o;
   logic sdata_m_oe;
   logic sdata_s_o;
   logic sdata_s_oe;
   logic sdata;

   // An undriven line is held low by the bus keeper
   assign sdata = sdata_m_oe ? sdata_m_o : (sdata_s_oe ? sdata_s_o : 1'b0);

   modport master (
      output sclk,
      output io_supply_enable,
      output sdata_m_o,
      output sdata_m_oe,
      input sdata
   );

   modport slave (
      input sclk,
      input io_supply_enable,
      output sdata_s_o,
      output sdata_s_oe,
      input sdata
   );
endinterface

// ===== fe_mode_sel.sv
// Operating state selection of the converter from register codes and comparator flags
module fe_mode_sel
   import fe_pkg::*;
   (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic analog_mode,
   input wire logic analog_level_input_on,
   input wire logic [1:0] analog_policy,
   input wire logic analog_level_input_above_half,
   input wire logic analog_level_input_above_high,
   input wire logic load_above_hi,
   input wire logic load_below_lo,
   input wire logic [6:0] level,
   input wire policy_t policy,
   input wire pstate_t pstate,
   input wire logic level_change,
   output op_mode_t op_mode,
   output logic switching_enable,
   output logic switch_node_pins_oe
   );

   typedef struct packed {
      op_mode_t op;
      logic heavy;
      logic [8:0] trans;
   } sel_t;

   sel_t r;
   sel_t n;
   policy_t pol;
   logic pwm;

   always_comb begin
      n = r;
      pol = analog_mode ? policy_t'(analog_policy) : policy;
      // Load hysteresis between the two current thresholds
      if (load_above_hi) begin
         n.heavy = 1'b1;
      end else if (load_below_lo) begin
         n.heavy = 1'b0;
      end
      if (level_change) begin
         n.trans = TRANS_LOAD;
      end else if (r.trans != '0) begin
         n.trans = r.trans - 9'h1;
      end
      case (pol)
         POLICY_PFM: pwm = 1'b0;
         POLICY_LOW_V: pwm = analog_mode ? analog_level_input_above_half : (level >= LEVEL_PWM_DIG);
         POLICY_LOAD: pwm = r.heavy | (analog_mode ? analog_level_input_above_high : (level >= LEVEL_PWM_LOAD));
         default: pwm = 1'b1;
      endcase
      if (analog_mode) begin
         n.op = !analog_level_input_on ? OP_LOW : (pwm ? OP_PWM : OP_PFM);
      end else if (pstate == PS_LOW) begin
         n.op = OP_LOW;
      end else if (level == LEVEL_LOW_POWER) begin
         n.op = OP_LOW;
      end else if (level == LEVEL_STANDBY && pstate == PS_NORMAL) begin
         n.op = OP_STBY;
      end else if (r.trans != '0) begin
         n.op = OP_PWM;
      end else begin
         n.op = pwm ? OP_PWM : OP_PFM;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         r <= '{op: OP_LOW, heavy: 1'b0, trans: 9'h000};
      end else begin
         r <= n;
      end
   end

   assign op_mode = r.op;
   // Power stage and switch nodes are off outside PFM and PWM
   assign switching_enable = (r.op == OP_PFM) || (r.op == OP_PWM);
   assign switch_node_pins_oe = (r.op == OP_PFM) || (r.op == OP_PWM);
endmodule

// ===== fe_slave.sv
// Serial slave port, register set and operating state of the converter control
//
// Our own choices: the register offsets and the address-and-strobe port.

// How it works
// - Level 00h or power state 10b: low power
// - Serial port keeps working in low power
// - Registers survive low power unchanged
// - Level 02h with state 00b: standby
// - Standby stops switching, logic stays alive
// - Standby releases the switch node pins
// - Policy 01: PWM from level 29h or comparator
// - Policy 10: PWM from 39h or heavy load
// - Level change forces PWM for a while
// - Supply rise enables port, loads defaults
// - Supply low resets interface asynchronously
// - Supply loss clears interface and registers
// - Each party drives data only in turn
// - Sender changes data on clock rise
// - Receiver samples data on clock fall
// - Master holds lines low without supply
// - Slave only, never starts a transfer
// - Broadcast address 0000b accepted
// - Unique 0101b and group 0000b accepted
// - Policy codes: PFM, low-V, load, PWM
// - Power state codes, default 01b
// - Seven bit level code, default 00h
module fe_slave
   import fe_pkg::*;
   #(
   parameter logic [7:0] PRODUCT_ID = 8'h5a // Arbitrary identification value
   )
   (
   input wire logic clk_sys,
   input wire logic reset,
   fe_link_if.slave link,
   input wire logic analog_mode,
   input wire logic analog_level_input_on,
   input wire logic [1:0] analog_policy,
   input wire logic analog_level_input_above_half,
   input wire logic analog_level_input_above_high,
   input wire logic load_above_hi,
   input wire logic load_below_lo,
   output op_mode_t op_mode,
   output logic switching_enable,
   output logic switch_node_pins_oe,
   output logic [6:0] output_level_code,
   output logic aux_output_a,
   output logic aux_output_b
   );

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_HDR = 3'b001,
      S_DATA = 3'b010,
      S_RD_PARK = 3'b011,
      S_RD = 3'b100,
      S_RD_END = 3'b101
   } slv_state_t;

   typedef struct packed {
      slv_state_t st;
      logic [2:0] sc;
      logic [2:0] sd;
      logic scl;
      logic sda;
      logic [3:0] cnt;
      logic [12:0] sh;
      logic [4:0] addr;
      logic [6:0] level;
      policy_t policy;
      pstate_t pstate;
      logic [1:0] aux;
      logic [5:0] trig;
      logic sdo;
      logic soe;
      logic lvl_chg;
   } slv_t;

   localparam slv_t SLV_RST = '{
      st: S_IDLE,
      level: LEVEL_RESET,
      policy: POLICY_RESET,
      pstate: PS_DEFAULT,
      default: '0
   };

   slv_t r;
   slv_t n;
   logic link_rst;
   logic rise;
   logic fall;
   logic ssc;
   logic hit;
   logic we;
   logic [4:0] wa;
   logic [7:0] wd;
   logic [12:0] hdr;
   logic [8:0] dat;
   logic [7:0] cmd;
   logic [7:0] rdv;

   // ****************************************
   // Reset from the interface supply pin
   // ****************************************
   assign link_rst = reset | ~link.io_supply_enable;

   // ****************************************
   // Frame decoding and register set
   // ****************************************
   always_comb begin
      n = r;
      n.sc = {r.sc[1:0], link.sclk};
      n.sd = {r.sd[1:0], link.sdata};
      if (r.sc[1] == r.sc[2]) begin
         n.scl = r.sc[2];
      end
      if (r.sd[1] == r.sd[2]) begin
         n.sda = r.sd[2];
      end
      rise = n.scl & ~r.scl;
      fall = ~n.scl & r.scl;
      // Data only changes with the clock low at a sequence start
      ssc = ~n.sda & r.sda & ~n.scl;
      n.lvl_chg = 1'b0;
      hdr = {r.sh[11:0], r.sda};
      dat = {r.sh[7:0], r.sda};
      cmd = hdr[8:1];
      hit = (hdr[12:9] == SID_UNIQUE) || (hdr[12:9] == SID_GROUP)
         || (hdr[12:9] == SID_BCAST);
      we = 1'b0;
      wa = r.addr;
      wd = dat[8:1];
      case (cmd[4:0])
         ADDR_LEVEL: rdv = {1'b0, r.level};
         ADDR_POLICY: rdv = {r.policy, 6'h00};
         ADDR_AUX: rdv = {r.aux, 6'h00};
         ADDR_TRIG: rdv = {r.pstate, r.trig};
         ADDR_PRODUCT: rdv = PRODUCT_ID;
         default: rdv = 8'h00;
      endcase
      if (ssc) begin
         n.st = S_HDR;
         n.cnt = '0;
         n.soe = 1'b0;
      end else begin
         case (r.st)
            S_HDR: begin
               if (fall) begin
                  n.sh = hdr;
                  n.cnt = r.cnt + 4'h1;
                  if (r.cnt == HDR_LAST) begin
                     n.cnt = '0;
                     n.st = S_IDLE;
                     if (hit && hdr[0] == odd_par(hdr[12:1])) begin
                        if (cmd[7]) begin
                           we = 1'b1;
                           wa = ADDR_LEVEL;
                           wd = {1'b0, cmd[6:0]};
                        end else if (cmd[7:5] == CMD_WRITE) begin
                           n.addr = cmd[4:0];
                           n.st = S_DATA;
                        end else if (cmd[7:5] == CMD_READ && hdr[12:9] == SID_UNIQUE) begin
                           n.sh = {4'h0, rdv, odd_par({4'h0, rdv})};
                           n.st = S_RD_PARK;
                        end
                     end
                  end
               end
            end
            S_DATA: begin
               if (fall) begin
                  n.sh = {r.sh[11:0], r.sda};
                  n.cnt = r.cnt + 4'h1;
                  if (r.cnt == DATA_LAST) begin
                     n.cnt = '0;
                     n.st = S_IDLE;
                     we = (dat[0] == odd_par({4'h0, dat[8:1]}));
                  end
               end
            end
            S_RD_PARK: begin
               if (fall) begin
                  n.st = S_RD;
               end
            end
            S_RD: begin
               if (rise) begin
                  n.sdo = r.sh[8];
                  n.sh = {r.sh[11:0], 1'b0};
                  n.soe = 1'b1;
               end
               if (fall) begin
                  n.cnt = r.cnt + 4'h1;
                  if (r.cnt == DATA_LAST) begin
                     n.cnt = '0;
                     n.st = S_RD_END;
                  end
               end
            end
            S_RD_END: begin
               if (rise) begin
                  n.sdo = 1'b0;
               end
               if (fall) begin
                  n.soe = 1'b0;
                  n.st = S_IDLE;
               end
            end
            default: n.st = S_IDLE;
         endcase
      end
      // Low power and standby never touch the stored settings
      if (we) begin
         case (wa)
            ADDR_LEVEL: begin
               n.level = wd[6:0];
               n.lvl_chg = (wd[6:0] != r.level);
            end
            ADDR_POLICY: n.policy = policy_t'(wd[FLD_HI -: 2]);
            ADDR_AUX: n.aux = wd[FLD_HI -: 2];
            ADDR_TRIG: begin
               n.pstate = pstate_t'(wd[FLD_HI -: 2]);
               n.trig = wd[TRIG_HI:0];
            end
            default: n.trig = r.trig;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge link_rst) begin
      if (link_rst) begin
         r <= SLV_RST;
      end else begin
         r <= n;
      end
   end

   // ****************************************
   // Pins and operating state
   // ****************************************
   assign link.sdata_s_o = r.sdo;
   assign link.sdata_s_oe = r.soe;
   assign output_level_code = r.level;
   assign aux_output_a = r.aux[1];
   assign aux_output_b = r.aux[0];

   fe_mode_sel u_mode (
      .clk_sys(clk_sys),
      .reset(reset),
      .analog_mode(analog_mode),
      .analog_level_input_on(analog_level_input_on),
      .analog_policy(analog_policy),
      .analog_level_input_above_half(analog_level_input_above_half),
      .analog_level_input_above_high(analog_level_input_above_high),
      .load_above_hi(load_above_hi),
      .load_below_lo(load_below_lo),
      .level(r.level),
      .policy(r.policy),
      .pstate(r.pstate),
      .level_change(r.lvl_chg),
      .op_mode(op_mode),
      .switching_enable(switching_enable),
      .switch_node_pins_oe(switch_node_pins_oe)
   );
endmodule

// ===== fe_master.sv
// Single bus master of the control link with a plain register command port
module fe_master
   import fe_pkg::*;
   (
   input wire logic clk_sys,
   input wire logic reset,
   fe_link_if.master link,
   input wire logic [1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
   );

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_SSC = 3'b001,
      H_BITS = 3'b010,
      H_TURN = 3'b011,
      H_RDBITS = 3'b100,
      H_PARK = 3'b101
   } mst_state_t;

   typedef struct packed {
      mst_state_t st;
      logic [2:0] hs;
      logic sda;
      logic [3:0] div;
      logic sclk;
      logic sdo;
      logic soe;
      logic [FRM_BITS-1:0] sh;
      logic [4:0] cnt;
      logic [4:0] last;
      logic is_read;
      logic [8:0] rsh;
      logic [7:0] rbyte;
      logic done;
      logic perr;
      logic supply;
      logic [31:0] rd_out;
   } mst_t;

   mst_t r;
   mst_t n;
   logic tick;
   logic [1:0] kind;
   logic [11:0] hdr;
   logic [7:0] dat;
   logic [31:0] stat;

   always_comb begin
      n = r;
      n.hs = {r.hs[1:0], link.sdata};
      if (r.hs[1] == r.hs[2]) begin
         n.sda = r.hs[2];
      end
      tick = (r.div == HALF_LAST);
      n.div = tick ? 4'h0 : r.div + 4'h1;
      kind = wdata[KIND_LO +: 2];
      dat = wdata[WDAT_LO +: 8];
      if (kind == KIND_REG0) begin
         hdr = {wdata[SID_LO +: 4], 1'b1, wdata[WDAT_LO +: 7]};
      end else begin
         hdr = {wdata[SID_LO +: 4], (kind == KIND_READ) ? CMD_READ : CMD_WRITE,
            wdata[ADDR_LO +: 5]};
      end
      stat = '0;
      stat[ST_BUSY] = (r.st != H_IDLE) || !r.soe;
      stat[ST_DONE] = r.done;
      stat[ST_PERR] = r.perr;
      stat[ST_SUPPLY] = r.supply;
      stat[ST_RDATA_LO +: 8] = r.rbyte;
      n.rd_out = '0;
      if (rd && addr == HREG_STATUS) begin
         n.rd_out = stat;
      end else if (rd && addr == HREG_SUPPLY) begin
         n.rd_out = {31'h00000000, r.supply};
      end
      if (wr && addr == HREG_SUPPLY) begin
         n.supply = wdata[0];
      end
      if (!r.supply) begin
         n.st = H_IDLE;
         n.sclk = 1'b0;
         n.sdo = 1'b0;
         n.soe = 1'b1;
      end else begin
         case (r.st)
            H_IDLE: begin
               // After a read the line is retaken only once the slave has let go
               if (!r.soe) begin
                  if (tick) begin
                     n.soe = 1'b1;
                     n.done = 1'b1;
                  end
               end else if (wr && addr == HREG_CMD) begin
                  n.sh = {hdr, odd_par(hdr), dat, odd_par({4'h0, dat})};
                  n.last = (kind == KIND_REG0 || kind == KIND_READ) ? SHORT_LAST : LONG_LAST;
                  n.is_read = (kind == KIND_READ);
                  n.done = 1'b0;
                  n.perr = 1'b0;
                  n.sdo = 1'b1;
                  n.div = 4'h0;
                  n.cnt = '0;
                  n.st = H_SSC;
               end
            end
            H_SSC: begin
               if (tick) begin
                  n.sdo = 1'b0;
                  n.st = H_BITS;
               end
            end
            H_BITS: begin
               if (tick && !r.sclk) begin
                  n.sclk = 1'b1;
                  n.sdo = r.sh[FRM_BITS-1];
                  n.sh = {r.sh[FRM_BITS-2:0], 1'b0};
               end else if (tick) begin
                  n.sclk = 1'b0;
                  n.cnt = r.cnt + 5'h01;
                  if (r.cnt == r.last) begin
                     n.cnt = '0;
                     n.st = r.is_read ? H_TURN : H_PARK;
                  end
               end
            end
            H_TURN: begin
               if (tick && !r.sclk) begin
                  n.sclk = 1'b1;
                  n.sdo = 1'b0;
               end else if (tick) begin
                  n.sclk = 1'b0;
                  n.soe = 1'b0;
                  n.st = H_RDBITS;
               end
            end
            H_RDBITS: begin
               if (tick && !r.sclk) begin
                  n.sclk = 1'b1;
               end else if (tick) begin
                  n.sclk = 1'b0;
                  n.rsh = {r.rsh[7:0], r.sda};
                  n.cnt = r.cnt + 5'h01;
                  if (r.cnt == RD_LAST) begin
                     n.cnt = '0;
                     n.st = H_PARK;
                  end
               end
            end
            H_PARK: begin
               if (tick && !r.sclk) begin
                  n.sclk = 1'b1;
                  n.sdo = 1'b0;
               end else if (tick) begin
                  n.sclk = 1'b0;
                  n.sdo = 1'b0;
                  n.done = !r.is_read;
                  n.st = H_IDLE;
                  if (r.is_read) begin
                     n.rbyte = r.rsh[8:1];
                     n.perr = (r.rsh[0] != odd_par({4'h0, r.rsh[8:1]}));
                  end
               end
            end
            default: n.st = H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         r <= '{st: H_IDLE, soe: 1'b1, default: '0};
      end else begin
         r <= n;
      end
   end

   assign link.sclk = r.sclk;
   assign link.sdata_m_o = r.sdo;
   assign link.sdata_m_oe = r.soe;
   assign link.io_supply_enable = r.supply;
   assign rdata = r.rd_out;
endmodule

// ===== fe_link_sva.sv
// Protocol checks on the control link between the master and the slave
module fe_link_sva (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic sclk,
   input wire logic io_supply_enable,
   input wire logic sdata_m_o,
   input wire logic sdata_m_oe,
   input wire logic sdata_s_o,
   input wire logic sdata_s_oe,
   input wire logic sdata
   );
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Length of one slave read answer
   // ****************************************
   logic [8:0] drive_cnt_reg;
   logic [8:0] drive_cnt_next;

   always_comb begin
      drive_cnt_next = sdata_s_oe ? drive_cnt_reg + 9'h001 : 9'h000;
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         drive_cnt_reg <= 9'h000;
      end else begin
         drive_cnt_reg <= drive_cnt_next;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   a_idle_lines_low: assert property (!io_supply_enable |-> !sclk && !sdata)
      else $error("link lines not low without supply");
   a_single_driver: assert property (!(sdata_m_oe && sdata_s_oe))
      else $error("both ends drive the data line");
   a_slave_off_nosup: assert property (!io_supply_enable |-> !sdata_s_oe)
      else $error("slave drives without supply");
   a_master_hold_high: assert property (sclk && $past(sclk) && sdata_m_oe && $past(sdata_m_oe)
      |-> $stable(sdata_m_o))
      else $error("master data moved while clock high");
   a_slave_change_rise: assert property (sdata_s_oe && $past(sdata_s_oe) && $changed(sdata_s_o)
      |-> sclk)
      else $error("slave data moved while clock low");
   a_slave_set_fall: assert property ($fell(sclk) && sdata_s_oe
      |-> sdata_s_o == $past(sdata_s_o, 4))
      else $error("slave data not settled at clock fall");
   a_half_period: assert property ($rose(sclk) |=> sclk [*8] ##1 sclk ##1 !sclk)
      else $error("clock high phase not ten cycles");
   a_slave_waits: assert property ($rose(sdata_s_oe) |-> $past(sdata_m_oe, 3) == 1'b0)
      else $error("slave took the line from the master");
   a_read_length: assert property ($fell(sdata_s_oe)
      |-> drive_cnt_reg >= 9'hb4 && drive_cnt_reg <= 9'hc8)
      else $error("slave answer of wrong length");
endmodule

// ===== tb_top.sv
// Bench of the control link: master command port against the converter slave
module tb_top
   import fe_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic analog_mode = 1'b0;
   logic analog_level_input_on = 1'b0;
   logic [1:0] analog_policy = 2'h0;
   logic analog_level_input_above_half = 1'b0;
   logic analog_level_input_above_high = 1'b0;
   logic load_above_hi = 1'b0;
   logic load_below_lo = 1'b1;
   op_mode_t op_mode;
   logic switching_enable, switch_node_pins_oe, aux_output_a, aux_output_b;
   logic [6:0] output_level_code;
   logic [7:0] rb;
   int error_cnt = 0;
   int total_checks = 0;

   fe_link_if link_i();
   fe_master fe_master_i(.clk_sys(clk_sys), .reset(reset), .link(link_i.master), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   fe_slave fe_slave_i(.clk_sys(clk_sys), .reset(reset), .link(link_i.slave),
      .analog_mode(analog_mode), .analog_level_input_on(analog_level_input_on), .analog_policy(analog_policy),
      .analog_level_input_above_half(analog_level_input_above_half), .analog_level_input_above_high(analog_level_input_above_high),
      .load_above_hi(load_above_hi), .load_below_lo(load_below_lo), .op_mode(op_mode),
      .switching_enable(switching_enable), .switch_node_pins_oe(switch_node_pins_oe),
      .output_level_code(output_level_code), .aux_output_a(aux_output_a),
      .aux_output_b(aux_output_b));
   fe_link_sva fe_link_sva_i(.clk_sys(clk_sys), .reset(reset), .sclk(link_i.sclk),
      .io_supply_enable(link_i.io_supply_enable), .sdata_m_o(link_i.sdata_m_o),
      .sdata_m_oe(link_i.sdata_m_oe), .sdata_s_o(link_i.sdata_s_o),
      .sdata_s_oe(link_i.sdata_s_oe), .sdata(link_i.sdata));

   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("mismatches %0d, checks %0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [1:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // One link frame, waits for done and keeps the last read byte
   task automatic frame(input logic [1:0] kind, input logic [3:0] sid, input logic [4:0] ra,
      input logic [7:0] dat);
      logic [31:0] st;
      int n;
      st = 32'h0;
      n = 0;
      wr_reg(HREG_CMD, {8'h00, dat, 3'h0, ra, sid, 2'h0, kind});
      while (st[ST_DONE] !== 1'b1 && n < 2000) begin
         rd_reg(HREG_STATUS, st);
         n++;
      end
      rb = st[15:8];
      if (st[ST_DONE] !== 1'b1) begin
         error_cnt++;
         report_and_stop();
      end
   endtask

   task automatic wr_dev(input logic [3:0] sid, input logic [4:0] ra, input logic [7:0] d);
      frame(KIND_WRITE, sid, ra, d);
   endtask

   task automatic rd_chk(input logic [4:0] ra, input logic [7:0] e);
      frame(KIND_READ, SID_UNIQUE, ra, 8'h00);
      chk(32'(rb), 32'(e));
   endtask

   task automatic mode_chk(input op_mode_t e);
      repeat (450) @(posedge clk_sys);
      #1 chk(32'(op_mode), 32'(e));
      @(posedge clk_sys);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      wr_reg(HREG_SUPPLY, 32'h1);
      repeat (8) @(posedge clk_sys);
      rd_chk(ADDR_LEVEL, 8'h00);
      rd_chk(ADDR_POLICY, 8'h40);
      rd_chk(ADDR_TRIG, 8'h40);
      mode_chk(OP_LOW);
      frame(KIND_REG0, SID_UNIQUE, 5'h00, 8'h28);
      chk(32'(op_mode), 32'(OP_PWM));
      mode_chk(OP_PFM);
      wr_dev(SID_BCAST, ADDR_LEVEL, 8'h29);
      mode_chk(OP_PWM);
      wr_dev(4'h3, ADDR_LEVEL, 8'h11);
      chk(32'(output_level_code), 32'h29);
      wr_dev(SID_UNIQUE, ADDR_POLICY, 8'h80);
      wr_dev(SID_UNIQUE, ADDR_LEVEL, 8'h38);
      mode_chk(OP_PFM);
      load_above_hi <= 1'b1;
      load_below_lo <= 1'b0;
      mode_chk(OP_PWM);
      load_above_hi <= 1'b0;
      load_below_lo <= 1'b1;
      mode_chk(OP_PFM);
      wr_dev(SID_UNIQUE, ADDR_LEVEL, 8'h39);
      mode_chk(OP_PWM);
      wr_dev(SID_UNIQUE, ADDR_POLICY, 8'h00);
      mode_chk(OP_PFM);
      wr_dev(SID_UNIQUE, ADDR_POLICY, 8'hc0);
      mode_chk(OP_PWM);
      wr_dev(SID_UNIQUE, ADDR_AUX, 8'h80);
      chk({30'h0, aux_output_a, aux_output_b}, 32'h2);
      wr_dev(SID_UNIQUE, ADDR_TRIG, 8'h00);
      wr_dev(SID_UNIQUE, ADDR_LEVEL, 8'h02);
      mode_chk(OP_STBY);
      chk({30'h0, switching_enable, switch_node_pins_oe}, 32'h0);
      rd_chk(ADDR_LEVEL, 8'h02);
      wr_dev(SID_UNIQUE, ADDR_LEVEL, 8'h50);
      wr_dev(SID_UNIQUE, ADDR_TRIG, 8'h80);
      mode_chk(OP_LOW);
      rd_chk(ADDR_LEVEL, 8'h50);
      wr_dev(SID_UNIQUE, ADDR_TRIG, 8'h00);
      mode_chk(OP_PWM);
      analog_mode <= 1'b1;
      analog_level_input_on <= 1'b1;
      analog_policy <= 2'b01;
      analog_level_input_above_half <= 1'b1;
      mode_chk(OP_PWM);
      analog_level_input_above_half <= 1'b0;
      analog_level_input_above_high <= 1'b1;
      mode_chk(OP_PFM);
      analog_mode <= 1'b0;
      wr_reg(HREG_SUPPLY, 32'h0);
      repeat (4) @(posedge clk_sys);
      chk({23'h0, output_level_code, aux_output_a, aux_output_b}, 32'h0);
      wr_reg(HREG_SUPPLY, 32'h1);
      repeat (8) @(posedge clk_sys);
      rd_chk(ADDR_POLICY, 8'h40);
      wr_dev(SID_UNIQUE, ADDR_LEVEL, 8'h50);
      frame(KIND_REG0, SID_GROUP, 5'h00, 8'h00);
      mode_chk(OP_LOW);
      report_and_stop();
   end
endmodule
